// *** hdl/cmr_top.sv ***
`timescale 1ns/10ps
// How it works
// - Two-bit frequency select maps 00/11 to 8, 01 to 16, 10 to 12 MHz.
// - Unimplemented flag register bits read back as zero.
// - Low-voltage reset event sets its sticky flag.
// - Undefined voltage code sets config-invalid flag and requests software reset.
// - Invalid watchdog-control write reset sets its flag.
// - Reset-cause flags clear only by software writing zero.
// - Speed and divider pick normal/slow; only halt strobe enters sleep/idle.
// - Halt chooses idle or sleep from idle-enable and clock-in-idle bits.
// - Speed low selects divided high-speed clock or sub clock by divider code.
// - Sub clock selection stops high-speed oscillator and its derived clocks.
// - Speed 0 with divider 000 or 001 enters slow mode.
// - Slow mode waits for low oscillator ready, reported by its flag.
// - Speed 1 or divider 010 to 111 returns to normal mode.
// - High oscillator ready flag reports stabilisation; software polls it.
// - Sleep entered only on halt with idle-enable at zero.
// - Sleep stops system and time-base clocks; sub clock keeps running.
// - Sleep preserves memory, registers and port states.
// - Sleep entry clears the watchdog counter, which then counts on.
// - Sleep entry sets power-down flag and clears watchdog-expired flag.
// - Halt with idle-enable 1, clock-in-idle 0 stops system clock only.
// - Halt with both bits 1 halts execution; system clock keeps running.
module cmr_top #(
  parameter int HF_SETTLE = cmr_pkg::HF_SETTLE_CYC,
  parameter int LF_SETTLE = cmr_pkg::LF_SETTLE_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        HALT_STROBE,
  input  wire logic        LOW_VOLTAGE_RESET,
  input  wire logic        WDT_CONFIG_RESET,
  input  wire logic        LV_CODE_INVALID,
  input  wire logic        WAKE,
  output logic             SOFT_RESET_REQ,
  output logic [4:0]       HF_OSC_MHZ,
  output logic             HF_OSC_EN,
  output logic             HF_DIV_CLK_EN,
  output logic             SUB_CLK_SEL,
  output logic [2:0]       SYSCLK_DIV,
  output logic             SYSCLK_EN,
  output logic             TIMEBASE_EN,
  output logic             CPU_HALT,
  output logic             WDT_CLEAR,
  output logic [1:0]       POWER_STATE
);

  logic [7:0]          ctrl_q;
  logic [7:0]          mode_q;
  logic [1:0]          stat_q;
  cmr_pkg::cmr_pstate_t pstate_q;
  logic [15:0]         hf_cnt_q;
  logic [15:0]         lf_cnt_q;
  logic                hf_rdy_q;
  logic                lf_rdy_q;
  logic                aw_q;
  logic                w_q;
  logic [7:0]          awaddr_q;
  logic [31:0]         wdata_q;
  logic                wstrb0_q;
  logic                wr_go;
  logic                halt_go;
  logic                slow_sel;

  // Slow mode decode, used in several places
  function automatic logic is_slow(input logic speed, input logic [2:0] div);
    is_slow = !speed && (div[2:1] == 2'b00);
  endfunction

  assign slow_sel = is_slow(mode_q[cmr_pkg::MODE_SPEED_BIT], mode_q[cmr_pkg::MODE_DIV_LSB +: 3]);
  assign wr_go    = aw_q && w_q && !S_AXI_BVALID;
  assign halt_go  = HALT_STROBE && pstate_q == cmr_pkg::CMR_RUN;

  // Write address and data capture, either order
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_q     <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_q      <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb0_q <= S_AXI_WSTRB[0];
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
    end
  end

  // Ready strobes and write response
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'b00;
    end else begin
      S_AXI_AWREADY <= !aw_q && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_q && !S_AXI_WREADY && S_AXI_WVALID;
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (awaddr_q[7:2] <= cmr_pkg::STATUS_OFFSET[7:2]) ? 2'b00 : 2'b10;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Flag and control register; hardware set wins over software clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl_q <= cmr_pkg::CTRL_RESET;
    end else begin
      if (wr_go && wstrb0_q && awaddr_q == cmr_pkg::CTRL_OFFSET) begin
        ctrl_q[cmr_pkg::CTRL_SYSON_BIT]       <= wdata_q[cmr_pkg::CTRL_SYSON_BIT];
        ctrl_q[cmr_pkg::CTRL_HFSEL_LSB +: 2]  <= wdata_q[cmr_pkg::CTRL_HFSEL_LSB +: 2];
        if (!wdata_q[cmr_pkg::CTRL_LOW_VOLTAGE_RESET_FLAG_BIT])
          ctrl_q[cmr_pkg::CTRL_LOW_VOLTAGE_RESET_FLAG_BIT] <= 1'b0;
        if (!wdata_q[cmr_pkg::CTRL_LRF_BIT])
          ctrl_q[cmr_pkg::CTRL_LRF_BIT] <= 1'b0;
        if (!wdata_q[cmr_pkg::CTRL_WRF_BIT])
          ctrl_q[cmr_pkg::CTRL_WRF_BIT] <= 1'b0;
      end
      if (LOW_VOLTAGE_RESET)
        ctrl_q[cmr_pkg::CTRL_LOW_VOLTAGE_RESET_FLAG_BIT] <= 1'b1;
      if (LV_CODE_INVALID)
        ctrl_q[cmr_pkg::CTRL_LRF_BIT] <= 1'b1;
      if (WDT_CONFIG_RESET)
        ctrl_q[cmr_pkg::CTRL_WRF_BIT] <= 1'b1;
      ctrl_q[6] <= 1'b0;
      ctrl_q[3] <= 1'b0;
    end
  end

  // Mode register: divider, idle enable, speed select
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mode_q <= cmr_pkg::MODE_RESET;
    end else begin
      if (wr_go && wstrb0_q && awaddr_q == cmr_pkg::MODE_OFFSET) begin
        mode_q[cmr_pkg::MODE_DIV_LSB +: 3]   <= wdata_q[cmr_pkg::MODE_DIV_LSB +: 3];
        mode_q[cmr_pkg::MODE_IDLE_ON_HALT_ENABLE_BIT]      <= wdata_q[cmr_pkg::MODE_IDLE_ON_HALT_ENABLE_BIT];
        mode_q[cmr_pkg::MODE_SPEED_BIT]      <= wdata_q[cmr_pkg::MODE_SPEED_BIT];
      end
      mode_q[cmr_pkg::MODE_LTO_BIT] <= lf_rdy_q;
      mode_q[cmr_pkg::MODE_HTO_BIT] <= hf_rdy_q;
      mode_q[4]                     <= 1'b0;
    end
  end

  // High oscillator settle counter, restarts when oscillator stops
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      hf_cnt_q <= 16'h0000;
      hf_rdy_q <= 1'b0;
    end else if (!HF_OSC_EN) begin
      hf_cnt_q <= 16'h0000;
      hf_rdy_q <= 1'b0;
    end else if (hf_cnt_q == 16'(HF_SETTLE - 1)) begin
      hf_rdy_q <= 1'b1;
    end else begin
      hf_cnt_q <= hf_cnt_q + 16'h0001;
    end
  end

  // Low oscillator settles once after reset and keeps running
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      lf_cnt_q <= 16'h0000;
      lf_rdy_q <= 1'b0;
    end else if (lf_cnt_q == 16'(LF_SETTLE - 1)) begin
      lf_rdy_q <= 1'b1;
    end else begin
      lf_cnt_q <= lf_cnt_q + 16'h0001;
    end
  end

  // Power state machine
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pstate_q <= cmr_pkg::CMR_RUN;
    end else begin
      case (pstate_q)
        cmr_pkg::CMR_RUN: begin
          if (halt_go) begin
            if (!mode_q[cmr_pkg::MODE_IDLE_ON_HALT_ENABLE_BIT])
              pstate_q <= cmr_pkg::CMR_SLEEP;
            else if (ctrl_q[cmr_pkg::CTRL_SYSON_BIT])
              pstate_q <= cmr_pkg::CMR_IDLE_CLOCK_RUNNING;
            else
              pstate_q <= cmr_pkg::CMR_IDLE_CLOCK_STOPPED;
          end
        end
        cmr_pkg::CMR_SLEEP,
        cmr_pkg::CMR_IDLE_CLOCK_STOPPED,
        cmr_pkg::CMR_IDLE_CLOCK_RUNNING: begin
          if (WAKE)
            pstate_q <= cmr_pkg::CMR_RUN;
        end
        default: pstate_q <= cmr_pkg::CMR_RUN;
      endcase
    end
  end

  // Status flags: power-down set and watchdog-expired cleared on halt
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      stat_q <= 2'b00;
    end else if (halt_go) begin
      stat_q[cmr_pkg::STAT_PDF_BIT] <= 1'b1;
      stat_q[cmr_pkg::STAT_TO_BIT]  <= 1'b0;
    end
  end

  // Clock steering outputs; power entry touches no register state but the status flags
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      HF_OSC_MHZ     <= cmr_pkg::HF_MHZ_00;
      HF_OSC_EN      <= 1'b1;
      HF_DIV_CLK_EN  <= 1'b1;
      SUB_CLK_SEL    <= 1'b0;
      SYSCLK_DIV     <= 3'h0;
      SYSCLK_EN      <= 1'b1;
      TIMEBASE_EN    <= 1'b1;
      CPU_HALT       <= 1'b0;
      WDT_CLEAR      <= 1'b0;
      SOFT_RESET_REQ <= 1'b0;
      POWER_STATE    <= 2'b00;
    end else begin
      case (ctrl_q[cmr_pkg::CTRL_HFSEL_LSB +: 2])
        2'b00:   HF_OSC_MHZ <= cmr_pkg::HF_MHZ_00;
        2'b01:   HF_OSC_MHZ <= cmr_pkg::HF_MHZ_01;
        2'b10:   HF_OSC_MHZ <= cmr_pkg::HF_MHZ_10;
        default: HF_OSC_MHZ <= cmr_pkg::HF_MHZ_11;
      endcase
      // Sub clock only after low oscillator settles
      SUB_CLK_SEL   <= slow_sel && lf_rdy_q;
      HF_OSC_EN     <= !(slow_sel && lf_rdy_q);
      HF_DIV_CLK_EN <= !(slow_sel && lf_rdy_q);
      // Divider code 2..7 gives fH/2..fH/64 when speed low
      SYSCLK_DIV    <= mode_q[cmr_pkg::MODE_SPEED_BIT] ? 3'h0
                       : 3'(mode_q[cmr_pkg::MODE_DIV_LSB +: 3] - 3'h1);
      SYSCLK_EN     <= pstate_q == cmr_pkg::CMR_RUN || pstate_q == cmr_pkg::CMR_IDLE_CLOCK_RUNNING;
      TIMEBASE_EN   <= pstate_q != cmr_pkg::CMR_SLEEP;
      CPU_HALT      <= pstate_q != cmr_pkg::CMR_RUN;
      WDT_CLEAR     <= halt_go;
      SOFT_RESET_REQ <= LV_CODE_INVALID;
      POWER_STATE   <= pstate_q;
    end
  end

  // Read channel
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= 2'b00;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= 2'b00;
        case (S_AXI_ARADDR)
          cmr_pkg::CTRL_OFFSET:   S_AXI_RDATA <= {24'h000000, ctrl_q & cmr_pkg::CTRL_IMPL_MASK};
          cmr_pkg::MODE_OFFSET:   S_AXI_RDATA <= {24'h000000, mode_q};
          cmr_pkg::STATUS_OFFSET: S_AXI_RDATA <= {30'h00000000, stat_q};
          default: begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= 2'b10;
          end
        endcase
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  sequence seq_halt_idle_clock_stopped;
    halt_go && mode_q[cmr_pkg::MODE_IDLE_ON_HALT_ENABLE_BIT] && !ctrl_q[cmr_pkg::CTRL_SYSON_BIT];
  endsequence

  sequence seq_halt_idle_clock_running;
    halt_go && mode_q[cmr_pkg::MODE_IDLE_ON_HALT_ENABLE_BIT] && ctrl_q[cmr_pkg::CTRL_SYSON_BIT];
  endsequence

  AST_FLAG_STICKY: assert property (@(posedge CLOCK) disable iff (RST)
    $fell(ctrl_q[cmr_pkg::CTRL_LOW_VOLTAGE_RESET_FLAG_BIT]) |-> $past(wr_go) && !$past(LOW_VOLTAGE_RESET))
    else $error("flag cleared without software write");
  AST_LV_SET: assert property (@(posedge CLOCK) disable iff (RST)
    LOW_VOLTAGE_RESET |=> ctrl_q[cmr_pkg::CTRL_LOW_VOLTAGE_RESET_FLAG_BIT])
    else $error("low voltage flag not set");
  AST_LRF_RESET: assert property (@(posedge CLOCK) disable iff (RST)
    LV_CODE_INVALID |=> ctrl_q[cmr_pkg::CTRL_LRF_BIT] && SOFT_RESET_REQ)
    else $error("invalid code not handled");
  AST_WRF_SET: assert property (@(posedge CLOCK) disable iff (RST)
    WDT_CONFIG_RESET |=> ctrl_q[cmr_pkg::CTRL_WRF_BIT])
    else $error("watchdog flag not set");
  AST_SLEEP_ENTRY: assert property (@(posedge CLOCK) disable iff (RST)
    halt_go && !mode_q[cmr_pkg::MODE_IDLE_ON_HALT_ENABLE_BIT] |=> pstate_q == cmr_pkg::CMR_SLEEP ##1 !SYSCLK_EN && !TIMEBASE_EN)
    else $error("sleep not entered");
  AST_IDLE_CLOCK_STOPPED: assert property (@(posedge CLOCK) disable iff (RST)
    seq_halt_idle_clock_stopped |=> ##1 !SYSCLK_EN && TIMEBASE_EN && CPU_HALT)
    else $error("idle_clock_stopped clocks wrong");
  AST_PDF: assert property (@(posedge CLOCK) disable iff (RST)
    halt_go |=> stat_q[cmr_pkg::STAT_PDF_BIT] && !stat_q[cmr_pkg::STAT_TO_BIT] && WDT_CLEAR)
    else $error("power-down flags wrong");
  AST_SUB_STOPS_HF: assert property (@(posedge CLOCK) disable iff (RST)
    SUB_CLK_SEL |-> !HF_OSC_EN && !HF_DIV_CLK_EN)
    else $error("high clock running on sub clock");
  AST_HALT_ONLY: assert property (@(posedge CLOCK) disable iff (RST)
    pstate_q == cmr_pkg::CMR_RUN && !HALT_STROBE |=> pstate_q == cmr_pkg::CMR_RUN)
    else $error("power state left run without halt");

  // Idle with the system clock kept: only execution stops
  AST_IDLE_CLOCK_RUNNING: assert property (@(posedge CLOCK) disable iff (RST)
    seq_halt_idle_clock_running |=> ##1 SYSCLK_EN && TIMEBASE_EN && CPU_HALT)
    else $error("idle_clock_running clocks wrong");

  // Frequency output follows the select code one cycle later
  AST_FREQ_16: assert property (@(posedge CLOCK) disable iff (RST)
    ctrl_q[cmr_pkg::CTRL_HFSEL_LSB +: 2] == 2'b01 |=> HF_OSC_MHZ == cmr_pkg::HF_MHZ_01)
    else $error("frequency code 01 not applied");
  AST_FREQ_12: assert property (@(posedge CLOCK) disable iff (RST)
    ctrl_q[cmr_pkg::CTRL_HFSEL_LSB +: 2] == 2'b10 |=> HF_OSC_MHZ == cmr_pkg::HF_MHZ_10)
    else $error("frequency code 10 not applied");
  AST_FREQ_8: assert property (@(posedge CLOCK) disable iff (RST)
    ctrl_q[cmr_pkg::CTRL_HFSEL_LSB] == ctrl_q[cmr_pkg::CTRL_HFSEL_LSB + 1] |=> HF_OSC_MHZ == cmr_pkg::HF_MHZ_00)
    else $error("frequency code 00 or 11 not applied");

  // Sub clock is never chosen before the low oscillator is ready
  AST_SLOW_WAITS_LF: assert property (@(posedge CLOCK) disable iff (RST)
    !lf_rdy_q |=> !SUB_CLK_SEL)
    else $error("sub clock selected before low oscillator ready");

  // Normal mode decode keeps the high-speed oscillator running
  AST_NORMAL_HF_ON: assert property (@(posedge CLOCK) disable iff (RST)
    !slow_sel |=> HF_OSC_EN && !SUB_CLK_SEL)
    else $error("high oscillator off in normal mode");

  // Watchdog clear is a single pulse per halt
  AST_WDT_PULSE: assert property (@(posedge CLOCK) disable iff (RST)
    WDT_CLEAR |=> !WDT_CLEAR)
    else $error("watchdog clear longer than one cycle");

  // Unimplemented flag register bits stay zero
  AST_CTRL_ZERO: assert property (@(posedge CLOCK) disable iff (RST)
    !ctrl_q[6] && !ctrl_q[3])
    else $error("unimplemented flag bit set");

endmodule

// *** hdl/cmr_pkg.sv ***
package cmr_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET    = 8'h00;
  localparam logic [7:0] MODE_OFFSET    = 8'h04;
  localparam logic [7:0] STATUS_OFFSET  = 8'h08;
  localparam logic [7:0] EVENT_OFFSET   = 8'h0c;
  // Flag and control register fields
  localparam int CTRL_SYSON_BIT  = 7;
  localparam int CTRL_HFSEL_LSB  = 4;
  localparam int CTRL_LOW_VOLTAGE_RESET_FLAG_BIT   = 2;
  localparam int CTRL_LRF_BIT    = 1;
  localparam int CTRL_WRF_BIT    = 0;
  localparam logic [7:0] CTRL_IMPL_MASK = 8'hb7;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  // Mode register fields
  localparam int MODE_DIV_LSB    = 5;
  localparam int MODE_LTO_BIT    = 3;
  localparam int MODE_HTO_BIT    = 2;
  localparam int MODE_IDLE_ON_HALT_ENABLE_BIT  = 1;
  localparam int MODE_SPEED_BIT  = 0;
  localparam logic [7:0] MODE_RESET     = 8'h01;
  // Status register fields
  localparam int STAT_PDF_BIT    = 0;
  localparam int STAT_TO_BIT     = 1;
  // Oscillator frequencies in MHz per select code
  localparam logic [4:0] HF_MHZ_00 = 5'h08;
  localparam logic [4:0] HF_MHZ_01 = 5'h10;
  localparam logic [4:0] HF_MHZ_10 = 5'h0c;
  localparam logic [4:0] HF_MHZ_11 = 5'h08;
  // Oscillator settle times in us and derived counts at 20 MHz
  localparam int CLK_MHZ        = 20;
  localparam int HF_SETTLE_US   = 16;
  localparam int LF_SETTLE_US   = 100;
  localparam int HF_SETTLE_CYC  = HF_SETTLE_US * CLK_MHZ;
  localparam int LF_SETTLE_CYC  = LF_SETTLE_US * CLK_MHZ;
  // Power states
  typedef enum logic [1:0] {
    CMR_RUN   = 2'b00,
    CMR_SLEEP = 2'b01,
    CMR_IDLE_CLOCK_STOPPED = 2'b10,
    CMR_IDLE_CLOCK_RUNNING = 2'b11
  } cmr_pstate_t;
endpackage

// *** verification/cmr_core_model.sv ***
`timescale 1ns/10ps
// Core side of the halt handshake: one strobe per executed halt
module cmr_core_model (
  input  wire logic clock,
  output logic      halt_strobe
);
  initial halt_strobe = 1'b0;

  // Raised just after one edge and dropped after the next, so the mode is decided once
  task automatic halt();
    @(posedge clock);
    halt_strobe <= 1'b1;
    @(posedge clock);
    halt_strobe <= 1'b0;
  endtask
endmodule

// *** verification/clock_mode_and_reset_flags_tb_top.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch at %0t: got %0h exp %0h", $time, g, e); end end
module clock_mode_and_reset_flags_tb_top;
  logic        clk = 1'b0, rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid, halt_strobe, soft_req, hf_en, div_en, sub;
  logic [1:0]  bresp, rresp, pstate;
  logic        low_voltage_reset = 1'b0, wdtr = 1'b0, lvinv = 1'b0, wake = 1'b0, sys_en, tb_en, cpu_halt, wdt_clr;
  logic [4:0]  mhz;
  logic [2:0]  div;
  logic [31:0] d;
  logic [1:0]  r;
  logic [7:0]  v;
  int          num_errors = 0, n_tests = 0, wdt_cnt = 0, w0;
  logic [4:0]  mhz_tab [4] = '{5'h08, 5'h10, 5'h0c, 5'h08};

  // Clock at 50 ns period
  initial forever #25 clk = ~clk;

  cmr_core_model core (.clock(clk), .halt_strobe(halt_strobe));

  cmr_top #(.HF_SETTLE(4), .LF_SETTLE(4)) uut (
    .CLOCK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .HALT_STROBE(halt_strobe), .LOW_VOLTAGE_RESET(low_voltage_reset),
    .WDT_CONFIG_RESET(wdtr), .LV_CODE_INVALID(lvinv), .WAKE(wake), .SOFT_RESET_REQ(soft_req),
    .HF_OSC_MHZ(mhz), .HF_OSC_EN(hf_en), .HF_DIV_CLK_EN(div_en), .SUB_CLK_SEL(sub), .SYSCLK_DIV(div),
    .SYSCLK_EN(sys_en), .TIMEBASE_EN(tb_en), .CPU_HALT(cpu_halt), .WDT_CLEAR(wdt_clr),
    .POWER_STATE(pstate));

  // Counts watchdog clear pulses seen from the block
  always @(posedge clk) if (wdt_clr === 1'b1) wdt_cnt <= wdt_cnt + 1;

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] x, output logic [1:0] resp);
    int n;
    @(posedge clk);
    awaddr <= a; wdata <= {24'h0, x}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (n == 50) begin num_errors++; close_out(); end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] resp);
    int n;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    x = rdata; resp = rresp;
    rready <= 1'b0;
    if (n == 50) begin num_errors++; close_out(); end
  endtask

  task automatic wchk(input logic [7:0] a, input logic [7:0] x);
    wr(a, x, r);
    `CHK(r, 2'b00)
    repeat (2) @(posedge clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] x);
    rd(a, d, r);
    `CHK(d, {24'h0, x})
  endtask

  // Polls a register until all mask bits are set
  task automatic poll(input logic [7:0] a, input logic [7:0] m);
    int n;
    for (n = 0; n < 20; n++) begin
      rd(a, d, r);
      if ((d[7:0] & m) === m) break;
    end
    if (n == 20) begin num_errors++; close_out(); end
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    `CHK(mhz, 5'h08)
    rchk(cmr_pkg::CTRL_OFFSET, 8'h00);
    poll(cmr_pkg::MODE_OFFSET, 8'h0c);
    rchk(cmr_pkg::MODE_OFFSET, 8'h0d);
    rd(cmr_pkg::EVENT_OFFSET, d, r);
    `CHK({r, d}, {2'b10, 32'h0})
    wr(cmr_pkg::EVENT_OFFSET, 8'h55, r);
    `CHK(r, 2'b10)
    $display("test reset_and_map done");
    for (int i = 0; i < 4; i++) begin
      wchk(cmr_pkg::CTRL_OFFSET, {2'b00, 2'(i), 4'h0});
      `CHK(mhz, mhz_tab[i])
    end
    wchk(cmr_pkg::CTRL_OFFSET, 8'hff);
    rchk(cmr_pkg::CTRL_OFFSET, 8'hb0);
    $display("test freq_select done");
    @(posedge clk);
    low_voltage_reset <= 1'b1; wdtr <= 1'b1; lvinv <= 1'b1;
    @(posedge clk);
    low_voltage_reset <= 1'b0; wdtr <= 1'b0; lvinv <= 1'b0;
    @(posedge clk);
    `CHK(soft_req, 1'b1)
    @(posedge clk);
    `CHK(soft_req, 1'b0)
    rchk(cmr_pkg::CTRL_OFFSET, 8'hb7);
    wchk(cmr_pkg::CTRL_OFFSET, 8'hb7);
    rchk(cmr_pkg::CTRL_OFFSET, 8'hb7);
    wchk(cmr_pkg::CTRL_OFFSET, 8'hb0);
    rchk(cmr_pkg::CTRL_OFFSET, 8'hb0);
    $display("test reset_flags done");
    for (int c = 0; c < 8; c++) begin
      wchk(cmr_pkg::MODE_OFFSET, {3'(c), 5'h00});
      `CHK({sub, hf_en, div_en}, (c < 2) ? 3'b100 : 3'b011)
      if (c >= 2) `CHK(div, 3'(c - 1))
      if (c == 2) poll(cmr_pkg::MODE_OFFSET, 8'h04);
      `CHK(pstate, 2'b00)
    end
    wchk(cmr_pkg::MODE_OFFSET, 8'h01);
    `CHK({sub, div}, 4'h0)
    $display("test mode_switch done");
    for (int i = 0; i < 4; i++) begin
      v = i[0] ? 8'hb0 : 8'h30;
      wchk(cmr_pkg::CTRL_OFFSET, v);
      wchk(cmr_pkg::MODE_OFFSET, {6'h00, i[1], 1'b1});
      w0 = wdt_cnt;
      core.halt();
      repeat (3) @(posedge clk);
      `CHK(pstate, i[1] ? {1'b1, i[0]} : 2'b01)
      `CHK({sys_en, tb_en, cpu_halt}, {i[1] & i[0], i[1], 1'b1})
      `CHK(wdt_cnt, w0 + 1)
      rchk(cmr_pkg::STATUS_OFFSET, 8'h01);
      rchk(cmr_pkg::CTRL_OFFSET, v);
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(pstate, 2'b00)
    end
    $display("test halt_modes done");
    close_out();
  end

  // Bounds the whole run
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule
